/* File: cfrf_core.sv */
// Sample FIFO and the channel filter, rounding and format stage
//
// Contract
// - Smoothing output is input times (1-k) plus last output times k.
// - Time constant in seconds; zero passes the input unchanged.
// - Filter disabled forwards each sample without filtering.
// - Peak registers once the signal leaves the extreme by the threshold.
// - Mode selects tracking of maxima or of minima.
// - A new peak while holding replaces the value and restarts the timer.
// - Held peak is output until hold expires, else the current value.
// - When enabled, a reset channel above zero clears the held peak.
// - Rounding works to the configured number of decimal places.
// - Rounding disabled keeps full precision; precision shapes presentation only.
// - Standard rounding: digit 0..4 rounds down, 5..9 rounds up.
// - Floor always rounds toward lower, ceiling always toward higher.
// - Binary view: above zero is on (1), zero or below is off (0).
// - Time view treats the value as seconds split by the time pattern.
// - Pattern needs higher units first; invalid pattern uses the default.
// - Precision ranges from zero to four decimal places.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps

// =========================================================
// Synchronous FIFO
module cfrf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Fill side
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  wr_ready,
  // Drain side
  output logic                  rd_valid,
  output logic [WIDTH-1:0]      rd_data,
  input  wire logic             rd_ready,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid = (cnt_q != '0);
  assign rd_data  = mem[rp_q];
  assign level    = cnt_q;
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cfrf_fifo

// =========================================================
// Channel processing stage
module cfrf_core #(
  parameter int unsigned TICK_CYCLES = cfrf_pkg::TICK_CYCLES,
  parameter int          FIFO_DEPTH  = 16
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Scaled sample stream, four decimal places
  input  wire logic          in_valid,
  input  wire logic [31:0]   in_data,
  output logic               in_ready,
  // Peak reset source channel value
  input  wire logic [31:0]   rst_src_value,
  // Processed outputs
  output logic               out_valid,
  output logic [31:0]        out_value,
  output logic [31:0]        out_present,
  output logic               out_binary,
  output logic               time_negative,
  output logic [159:0]       time_fields,
  output logic [14:0]        time_pattern
);
  // =========================================================
  // Register file
  logic [31:0] ctrl_q;
  logic [31:0] tconst_q;
  logic [31:0] thresh_q;
  logic [31:0] hold_q;
  logic [14:0] pattern_q;
  logic        acc;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_mux;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  assign acc   = psel & penable & pready;
  assign wr_en = acc & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      // One wait state keeps read data registered
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= (psel & penable & ~pready) ? rd_mux : '0;
    end
  end

  logic cfg_holding;
  logic cfg_pat_ok;

  always_comb begin
    hit    = 1'b1;
    rd_mux = '0;
    case (paddr)
      cfrf_pkg::REG_CTRL:    rd_mux = ctrl_q;
      cfrf_pkg::REG_TCONST:  rd_mux = tconst_q;
      cfrf_pkg::REG_THRESH:  rd_mux = thresh_q;
      cfrf_pkg::REG_HOLD:    rd_mux = hold_q;
      cfrf_pkg::REG_PATTERN: rd_mux = {17'h0, pattern_q};
      cfrf_pkg::REG_STATUS:  rd_mux = {16'h0, 8'(fifo_level), 6'h0, cfg_pat_ok, cfg_holding};
      cfrf_pkg::REG_VALUE:   rd_mux = out_value;
      default:               hit    = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= cfrf_pkg::CTRL_RESET;
      tconst_q  <= '0;
      thresh_q  <= '0;
      hold_q    <= '0;
      pattern_q <= cfrf_pkg::PATTERN_DEFAULT;
    end else if (wr_en) begin
      case (paddr)
        cfrf_pkg::REG_CTRL:    ctrl_q    <= pwdata;
        cfrf_pkg::REG_TCONST:  tconst_q  <= pwdata;
        cfrf_pkg::REG_THRESH:  thresh_q  <= pwdata;
        cfrf_pkg::REG_HOLD:    hold_q    <= pwdata;
        cfrf_pkg::REG_PATTERN: pattern_q <= pwdata[14:0];
        default: ;
      endcase
    end
  end

  cfrf_pkg::cfrf_filt_t filt_mode;
  cfrf_pkg::cfrf_rnd_t  rnd_mode;
  logic [2:0]           prec;
  assign filt_mode = cfrf_pkg::cfrf_filt_t'(ctrl_q[cfrf_pkg::CTRL_FILT_LSB +: 2]);
  assign rnd_mode  = cfrf_pkg::cfrf_rnd_t'(ctrl_q[cfrf_pkg::CTRL_RND_LSB +: 2]);
  // Values above four clamp to four places
  assign prec = (ctrl_q[cfrf_pkg::CTRL_PREC_LSB +: 3] > 3'(cfrf_pkg::PREC_MAX)) ?
                3'(cfrf_pkg::PREC_MAX) : ctrl_q[cfrf_pkg::CTRL_PREC_LSB +: 3];

  // =========================================================
  // Input FIFO and sample tick
  logic        s_valid;
  logic [31:0] s_data;
  logic        tick_q;
  logic [31:0] tick_cnt_q;
  logic        take;
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
  logic [LVL_W-1:0] level_n;

  cfrf_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_valid (in_valid & in_ready),
    .wr_data  (in_data),
    .wr_ready (),
    .rd_valid (s_valid),
    .rd_data  (s_data),
    .rd_ready (tick_q),
    .level    (fifo_level)
  );

  // Draining is paced by the tick, so a fast source fills the FIFO and stalls
  assign take = tick_q & s_valid;
  // Ready is a flop, so it looks one push or pop ahead
  assign level_n = fifo_level + LVL_W'(in_valid & in_ready) - LVL_W'(take);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (level_n != LVL_W'(FIFO_DEPTH));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // =========================================================
  // Smoothing coefficient k = exp(-0.1/w), cubic series in Q16
  logic [31:0] a_q16;
  logic [63:0] a2;
  logic [63:0] a3;
  logic [31:0] k_q;

  assign a_q16 = (tconst_q == '0) ? '0 : cfrf_pkg::STEP_Q16 / tconst_q;
  assign a2    = 64'(a_q16) * 64'(a_q16);
  assign a3    = a2 * 64'(a_q16);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_q <= '0;
    end else begin
      k_q <= cfrf_pkg::COEF_ONE - a_q16 + 32'(a2 >> (cfrf_pkg::COEF_FRAC + 1))
             - 32'((a3 >> (2 * cfrf_pkg::COEF_FRAC)) / 64'h6);
    end
  end

  logic signed [31:0] smooth_q;
  logic               seeded_q;
  logic signed [63:0] smooth_acc;
  logic signed [31:0] smooth_n;

  assign smooth_acc = $signed(s_data) * $signed({1'b0, cfrf_pkg::COEF_ONE - k_q})
                    + smooth_q * $signed({1'b0, k_q});
  always_comb begin
    if (!seeded_q || tconst_q == '0) begin
      smooth_n = $signed(s_data);
    end else begin
      smooth_n = 32'(smooth_acc >>> cfrf_pkg::COEF_FRAC);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smooth_q <= '0;
      seeded_q <= 1'b0;
    end else if (take) begin
      smooth_q <= smooth_n;
      seeded_q <= 1'b1;
    end
  end

  // =========================================================
  // Peak and valley detector
  logic signed [31:0] ext_q;
  logic               track_q;
  logic signed [31:0] held_q;
  logic               holding_q;
  logic [31:0]        hold_cnt_q;
  logic signed [32:0] away;
  logic               detect;
  logic               beyond;
  logic               minima;
  logic               ext_reset;

  assign minima    = ctrl_q[cfrf_pkg::CTRL_MINIMA];
  assign ext_reset = ctrl_q[cfrf_pkg::CTRL_RST_EN] & ($signed(rst_src_value) > 0);
  assign away   = minima ? (33'($signed(s_data)) - 33'(ext_q))
                         : (33'(ext_q) - 33'($signed(s_data)));
  assign beyond = minima ? ($signed(s_data) < ext_q) : ($signed(s_data) > ext_q);
  assign detect = track_q & (away >= $signed({1'b0, thresh_q}));
  assign cfg_holding = holding_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q      <= '0;
      track_q    <= 1'b0;
      held_q     <= '0;
      holding_q  <= 1'b0;
      hold_cnt_q <= '0;
    end else if (ext_reset) begin
      track_q   <= 1'b0;
      holding_q <= 1'b0;
    end else if (take && filt_mode == cfrf_pkg::FILT_PEAK) begin
      if (detect) begin
        held_q     <= ext_q;
        holding_q  <= 1'b1;
        hold_cnt_q <= '0;
        ext_q      <= $signed(s_data);
      end else begin
        if (!track_q || beyond) begin
          ext_q <= $signed(s_data);
        end
        if (holding_q) begin
          hold_cnt_q <= hold_cnt_q + 1'b1;
          if (hold_cnt_q + 1'b1 >= hold_q) begin
            holding_q <= 1'b0;
          end
        end
      end
      track_q <= 1'b1;
    end
  end

  // =========================================================
  // Filter select and stage register
  logic signed [31:0] filt_q;
  logic               filt_v_q;
  logic signed [31:0] peak_n;

  always_comb begin
    if (detect && !ext_reset) begin
      peak_n = ext_q;
    end else if (holding_q && !ext_reset && (hold_cnt_q + 1'b1 < hold_q)) begin
      peak_n = held_q;
    end else begin
      peak_n = $signed(s_data);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q   <= '0;
      filt_v_q <= 1'b0;
    end else begin
      filt_v_q <= take;
      if (take) begin
        case (filt_mode)
          cfrf_pkg::FILT_SMOOTH: filt_q <= smooth_n;
          cfrf_pkg::FILT_PEAK:   filt_q <= peak_n;
          default:               filt_q <= $signed(s_data);
        endcase
      end
    end
  end

  // =========================================================
  // Rounding, applied after filtering
  function automatic logic signed [32:0] floor_to(input logic signed [32:0] x,
                                                  input logic signed [32:0] d);
    logic signed [32:0] q;
    logic signed [32:0] r;
    q = x / d;
    r = x % d;
    if (r < 0) begin
      q = q - 1;
    end
    floor_to = 33'(q * d);
  endfunction : floor_to

  logic signed [32:0] step;
  logic signed [32:0] x33;
  logic signed [32:0] r_floor;
  logic signed [32:0] r_ceil;
  logic signed [32:0] r_std;
  logic signed [31:0] rounded;

  assign step    = $signed({1'b0, cfrf_pkg::POW10[3'(cfrf_pkg::PREC_MAX) - prec]});
  assign x33     = 33'(filt_q);
  assign r_floor = floor_to(x33, step);
  assign r_ceil  = (r_floor == x33) ? x33 : r_floor + step;
  assign r_std   = floor_to(x33 + (step >>> 1), step);

  always_comb begin
    case (rnd_mode)
      cfrf_pkg::RND_STD:   rounded = 32'(r_std);
      cfrf_pkg::RND_FLOOR: rounded = 32'(r_floor);
      cfrf_pkg::RND_CEIL:  rounded = 32'(r_ceil);
      default:             rounded = filt_q;
    endcase
  end

  // =========================================================
  // Time view
  logic [32:0] mag;
  logic [31:0] secs;
  logic [31:0] unit_tot [5];
  logic [31:0] unit_mod [5];
  logic [14:0] pat_use;
  logic        pat_ok;
  logic [159:0] fields_n;

  assign mag  = (rounded < 0) ? 33'(-33'(rounded)) : 33'(rounded);
  assign secs = 32'(mag / 33'(cfrf_pkg::ONE_UNIT));

  always_comb begin
    pat_ok = (pattern_q[2:0] != 3'h0);
    for (int i = 0; i < cfrf_pkg::SLOTS; i++) begin
      if (pattern_q[i*3 +: 3] > 3'h5) begin
        pat_ok = 1'b0;
      end
      if (i > 0 && pattern_q[i*3 +: 3] != 3'h0 &&
          pattern_q[i*3 +: 3] <= pattern_q[(i-1)*3 +: 3]) begin
        pat_ok = 1'b0;
      end
      if (i > 0 && pattern_q[i*3 +: 3] != 3'h0 && pattern_q[(i-1)*3 +: 3] == 3'h0) begin
        pat_ok = 1'b0;
      end
    end
  end
  assign pat_use    = pat_ok ? pattern_q : cfrf_pkg::PATTERN_DEFAULT;
  assign cfg_pat_ok = pat_ok;

  for (genvar u = 0; u < cfrf_pkg::SLOTS; u++) begin : g_unit
    assign unit_tot[u] = secs / cfrf_pkg::UNIT_SEC[u];
    assign unit_mod[u] = (u == 0) ? unit_tot[u] : unit_tot[u] % cfrf_pkg::UNIT_MOD[u];
  end

  for (genvar s = 0; s < cfrf_pkg::SLOTS; s++) begin : g_slot
    logic [2:0] code;
    assign code = pat_use[s*3 +: 3];
    // Leading unit absorbs everything above it
    assign fields_n[s*32 +: 32] = (code == 3'h0) ? 32'h0 :
                                  (s == 0) ? unit_tot[code - 3'h1] :
                                  unit_mod[code - 3'h1];
  end

  // =========================================================
  // Output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid     <= 1'b0;
      out_value     <= '0;
      out_present   <= '0;
      out_binary    <= 1'b0;
      time_negative <= 1'b0;
      time_fields   <= '0;
      time_pattern  <= cfrf_pkg::PATTERN_DEFAULT;
    end else begin
      out_valid    <= filt_v_q;
      time_pattern <= pat_use;
      if (filt_v_q) begin
        out_value     <= rounded;
        // Unrounded values are still shown at the chosen precision
        out_present   <= (rnd_mode == cfrf_pkg::RND_NONE) ? 32'(r_std) : rounded;
        out_binary    <= (rounded > 0);
        time_negative <= (rounded < 0);
        time_fields   <= fields_n;
      end
    end
  end
endmodule : cfrf_core

/* File: cfrf_pkg.sv */
// Constants, register map and mode types for the channel filter and format stage
package cfrf_pkg;
  // =========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam longint      SAMPLE_PERIOD_PS  = 64'd100000000000;  // 0.1 s
  localparam int unsigned TICK_CYCLES       = int'(SAMPLE_PERIOD_PS / CLK_PERIOD_PS);
  // =========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_TCONST    = 8'h04;
  localparam logic [7:0] REG_THRESH    = 8'h08;
  localparam logic [7:0] REG_HOLD      = 8'h0c;
  localparam logic [7:0] REG_PATTERN   = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_VALUE     = 8'h18;
  // =========================================================
  // Control field positions
  localparam int CTRL_FILT_LSB = 0;   // 2 bits
  localparam int CTRL_RND_LSB  = 2;   // 2 bits
  localparam int CTRL_PREC_LSB = 4;   // 3 bits
  localparam int CTRL_MINIMA   = 7;
  localparam int CTRL_RST_EN   = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // =========================================================
  // Value scaling: samples carry four decimal places
  localparam int unsigned PREC_MAX  = 4;
  localparam logic signed [32:0] ONE_UNIT = 33'sh0_0000_2710;  // 10000
  localparam logic [31:0] POW10 [5] = '{32'h1, 32'ha, 32'h64, 32'h3e8, 32'h2710};
  // Smoothing coefficient in Q16
  localparam int          COEF_FRAC = 16;
  localparam logic [31:0] COEF_ONE  = 32'h0001_0000;
  localparam logic [31:0] STEP_Q16  = 32'h0000_199a;  // 0.1 in Q16
  // =========================================================
  // Time pattern: five 3-bit slots, slot 0 in the low bits
  localparam int          SLOTS     = 5;
  localparam int          SLOT_W    = 3;
  localparam logic [14:0] PATTERN_DEFAULT = 15'h58d1;
  localparam logic [31:0] UNIT_SEC [5] = '{32'h93a80, 32'h15180, 32'he10, 32'h3c, 32'h1};
  localparam logic [31:0] UNIT_MOD [5] = '{32'h0, 32'h7, 32'h18, 32'h3c, 32'h3c};
  // =========================================================
  typedef enum logic [1:0] {FILT_OFF, FILT_SMOOTH, FILT_PEAK, FILT_RSVD} cfrf_filt_t;
  typedef enum logic [1:0] {RND_NONE, RND_STD, RND_FLOOR, RND_CEIL} cfrf_rnd_t;
endpackage : cfrf_pkg

/* File: cfrf_core_asserts.sv */
// Concurrent checks on the ports of the channel filter and format stage
`timescale 1ns/100ps
module cfrf_core_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Results
  input wire logic        out_valid,
  input wire logic [31:0] out_value,
  input wire logic [31:0] out_present,
  input wire logic        out_binary,
  input wire logic        time_negative,
  input wire logic [14:0] time_pattern
);
  // =========================================================
  // Shadow of the control word, so rounding checks know the mode
  logic [8:0]  ctrl_q;
  logic [31:0] step;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 9'h0;
    end else if (psel && penable && pready && pwrite && paddr == cfrf_pkg::REG_CTRL) begin
      ctrl_q <= pwdata[8:0];
    end
  end
  always_comb begin
    step = cfrf_pkg::POW10[4 - ((ctrl_q[6:4] > 3'h4) ? 3'h4 : ctrl_q[6:4])];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =========================================================
  // Assertions
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered in the next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without pready or with data");
  out_pulse_a: assert property (out_valid |=> !out_valid)
    else $error("out_valid high for more than one cycle");
  out_hold_a: assert property (!out_valid |-> $stable(out_value) && $stable(out_binary))
    else $error("result changed without out_valid");
  binary_view_a: assert property (out_valid |-> out_binary == ($signed(out_value) > 0))
    else $error("on/off view does not follow the value sign");
  time_sign_a: assert property (out_valid |-> time_negative == out_value[31])
    else $error("time sign does not follow the value");
  pattern_ok_a: assert property (time_pattern[2:0] inside {[3'h1:3'h5]})
    else $error("pattern in use has no valid first unit");
  round_grid_a: assert property (out_valid && ctrl_q[3:2] != 2'h0 |->
    $signed(out_value) % $signed(step) == 0)
    else $error("rounded value off the precision grid");
  present_same_a: assert property (out_valid && ctrl_q[3:2] != 2'h0 |->
    out_present == out_value)
    else $error("presented value differs from rounded value");
  cover property (pslverr);
  cover property (out_valid && out_binary);
  cover property (out_valid && time_negative);
endmodule : cfrf_core_asserts

bind cfrf_core cfrf_core_asserts u_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .out_valid, .out_value, .out_present, .out_binary,
  .time_negative, .time_pattern);

/* File: cfrf_src_model.sv */
// Upstream scaling stage: queues samples and offers them on the input stream
`timescale 1ns/100ps
module cfrf_src_model (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // One idle cycle after each word when set
  input  wire logic   slow,
  // Sample stream
  output logic        in_valid,
  output logic [31:0] in_data,
  input  wire logic   in_ready
);
  logic [31:0] words_q [$];
  task automatic push(input logic [31:0] v);
    words_q.push_back(v);
  endtask : push
  // Released data is inverted so a stale word never passes for a fresh one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words_q.delete();
      in_valid <= 1'b0;
      in_data  <= 32'h0;
    end else if (in_valid && in_ready && (slow || words_q.size() == 0)) begin
      in_valid <= 1'b0;
      in_data  <= ~in_data;
    end else if ((!in_valid || in_ready) && words_q.size() > 0) begin
      in_valid <= 1'b1;
      in_data  <= words_q.pop_front();
    end
  end
endmodule : cfrf_src_model

/* File: cfrf_core_tb.sv */
// Self-checking testbench for the channel filter, rounding and format stage
`timescale 1ns/100ps
module cfrf_core_tb;
  // =========================================================
  // Signals
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic         slow = 1'b0;
  logic         saw_full = 1'b0;
  logic [7:0]   paddr = 8'h0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  rst_src_value = 32'h0;
  logic         pready, pslverr, in_valid, in_ready, out_valid, out_binary, time_negative, err;
  logic [31:0]  prdata, in_data, out_value, out_present, rd;
  logic [159:0] time_fields;
  logic [14:0]  time_pattern;
  logic [31:0]  vals [2] = '{32'h0000_8708, 32'hffff_cfc7};
  logic [31:0]  t = 32'h0238_63d0;
  int           error_cnt = 0;
  int           checked = 0;

  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    if (presetn && !in_ready) begin
      saw_full <= 1'b1;
    end
  end

  cfrf_core #(.TICK_CYCLES(8), .FIFO_DEPTH(16)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_data, .in_ready,
    .rst_src_value, .out_valid, .out_value, .out_present, .out_binary, .time_negative,
    .time_fields, .time_pattern);
  cfrf_src_model u_src (.pclk, .presetn, .slow, .in_valid, .in_data, .in_ready);

  // =========================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check("pready", 32'h0, 32'h1);
  endtask : apb

  task automatic wait_out();
    int n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (out_valid !== 1'b1 && n < 400);
    if (n >= 400) check("out_valid", 32'h0, 32'h1);
  endtask : wait_out

  task automatic smp(input logic [31:0] v, input logic [31:0] e);
    u_src.push(v);
    wait_out();
    check("out_value", out_value, e);
  endtask : smp

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // Mode 1 standard, 2 floor, 3 ceiling; standard rounds half toward higher
  function automatic logic [31:0] rnd_exp(input logic [31:0] v, input int m, input int p);
    int s;
    int r;
    int f;
    s = 10 ** (4 - ((p > 4) ? 4 : p));
    r = $signed(v) % s;
    f = $signed(v) - r - ((r < 0) ? s : 0);
    if ((m == 3 && f != $signed(v)) || (m == 1 && ($signed(v) - f) * 2 >= s)) f += s;
    return 32'(f);
  endfunction : rnd_exp

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // =========================================================
  // Tests
  initial begin
    do_reset();
    apb(1'b0, cfrf_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", rd, cfrf_pkg::CTRL_RESET);
    apb(1'b0, cfrf_pkg::REG_PATTERN, 32'h0);
    check("pattern reset", rd, {17'h0, cfrf_pkg::PATTERN_DEFAULT});
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h3);
    smp(32'h1, 32'h1);
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h0);
    foreach (vals[i]) begin
      smp(vals[i], vals[i]);
      check("binary", {31'h0, out_binary}, {31'h0, !vals[i][31]});
    end
    smp(32'h0, 32'h0);
    check("binary zero", {31'h0, out_binary}, 32'h0);
    for (int m = 1; m < 4; m++) begin
      for (int p = 0; p < 6; p++) begin
        apb(1'b1, cfrf_pkg::REG_CTRL, 32'((m << 2) | (p << 4)));
        foreach (vals[i]) smp(vals[i], rnd_exp(vals[i], m, p));
      end
    end
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h20);
    smp(vals[1], vals[1]);
    check("present", out_present, rnd_exp(vals[1], 1, 2));
    apb(1'b1, cfrf_pkg::REG_PATTERN, 32'h23);
    smp(t, t);
    check("hours", time_fields[31:0], 32'h1);
    check("minutes", time_fields[63:32], 32'h2);
    check("pattern", {17'h0, time_pattern}, 32'h23);
    smp(-t, -t);
    check("negative", {31'h0, time_negative}, 32'h1);
    apb(1'b1, cfrf_pkg::REG_PATTERN, 32'h1c);
    apb(1'b0, cfrf_pkg::REG_STATUS, 32'h0);
    check("fallback", {17'h0, time_pattern}, {17'h0, cfrf_pkg::PATTERN_DEFAULT});
    check("status valid", {31'h0, rd[1]}, 32'h0);
    do_reset();
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h1);
    apb(1'b1, cfrf_pkg::REG_TCONST, 32'h1);
    smp(32'h0001_86a0, 32'h0001_86a0);
    u_src.push(32'h0);
    wait_out();
    // Coefficient is Q16 from a short series, so a small band is allowed
    check("decay", {31'h0, $signed(out_value) inside {[90400:90560]}}, 32'h1);
    apb(1'b1, cfrf_pkg::REG_TCONST, 32'h0);
    smp(32'h0001_1170, 32'h0001_1170);
    do_reset();
    slow <= 1'b1;
    apb(1'b1, cfrf_pkg::REG_THRESH, 32'h2710);
    apb(1'b1, cfrf_pkg::REG_HOLD, 32'h6);
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h2);
    smp(32'h2710, 32'h2710);
    smp(32'h7530, 32'h7530);
    smp(32'h61a8, 32'h61a8);
    smp(32'h3a98, 32'h7530);
    smp(32'h9c40, 32'h7530);
    smp(32'h61a8, 32'h9c40);
    repeat (10) u_src.push(32'h61a8);
    repeat (5) wait_out();
    check("held", out_value, 32'h9c40);
    repeat (5) wait_out();
    check("expired", out_value, 32'h61a8);
    do_reset();
    apb(1'b1, cfrf_pkg::REG_THRESH, 32'h2710);
    apb(1'b1, cfrf_pkg::REG_HOLD, 32'h64);
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h82);
    smp(32'h4e20, 32'h4e20);
    smp(32'h1388, 32'h1388);
    smp(32'h4e20, 32'h1388);
    rst_src_value <= 32'h2710;
    smp(32'h4e20, 32'h1388);
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h182);
    smp(32'h4e20, 32'h4e20);
    rst_src_value <= 32'h0;
    slow <= 1'b0;
    apb(1'b1, cfrf_pkg::REG_CTRL, 32'h0);
    saw_full = 1'b0;
    for (int i = 1; i <= 20; i++) u_src.push(32'(i));
    for (int i = 1; i <= 20; i++) begin
      wait_out();
      check("burst", out_value, 32'(i));
    end
    check("refused", {31'h0, saw_full}, 32'h1);
    apb(1'b0, cfrf_pkg::REG_STATUS, 32'h0);
    check("drained", {24'h0, rd[15:8]}, 32'h0);
    conclude();
  end

  initial begin
    #40000;
    check("watchdog", 32'h0, 32'h1);
    conclude();
  end
endmodule : cfrf_core_tb
